/* File: core/flash_seq.sv */
// Serial flash program, erase and power-mode sequencer with its array.
// Operation
// - Program and erase run only when the write enable latch is set.
// - Programming only clears bits; only erase sets them back to one.
// - Program address low byte steps and wraps inside the page.
// - Only the last 256 bytes program; untouched page bytes stay intact.
// - Program runs only if select rises on a byte boundary.
// - Progress flag is high during self-timed cycles; latch clears early.
// - Program or sector erase into a protected sector is not executed.
// - The top three address bits are ignored.
// - Sector erase sets every byte of the addressed sector to ones.
// - Sector erase runs only if select rises after 32 bits.
// - Bulk erase and power-down run only if select rises after 8 bits.
// - Bulk erase runs only when all protect bits are zero.
// - Deep power-down is reached only after the entry delay.
// - In deep power-down, write, program and erase are ignored.
// - Deselect alone leads to standby, never to deep power-down.
// - Power-down during a busy cycle is rejected.
// - Release takes three dummy bytes then repeats the signature.
// - Release is not decoded during a cycle; works when not down.
// - Release outside the entry delay ends in standby, at once or after the release delay; during entry it is ignored.
`timescale 1ns/1ps
`default_nettype none

module flash_seq import flash_seq_pkg::*; #(
  parameter int ADDR_W = 21,
  parameter int SECT_W = 16,
  parameter logic [7:0] SIGNATURE = 8'h5A, // Arbitrary value.
  parameter logic [7:0] OPC_WR_EN = 8'h06,
  parameter logic [7:0] OPC_PROG = 8'h02,
  parameter logic [7:0] OPC_SECT = 8'hD8,
  parameter logic [7:0] OPC_BULK = 8'hC7,
  parameter logic [7:0] OPC_DOWN = 8'hB9,
  parameter logic [7:0] OPC_REL = 8'hAB,
  parameter int PROG_CYC =
    (PROGRAM_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int ERASE_CYC =
    (SECTOR_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int BULK_CYC =
    (BULK_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int PD_CYC =
    (POWER_DOWN_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int REL_CYC =
    (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic [2:0] bp_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic so_o,
  output logic write_in_progress_o,
  output logic write_enable_latch_o,
  output logic deep_pd_o,
  output logic [7:0] rd_data_o
);

  // All assertions and covers below run on the main clock and rest during reset.
  default clocking main_cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // ****************************************
  // Parameter checks
  // ****************************************
  if (ADDR_W > ADDR_FULL_W - 3 || SECT_W <= PAGE_W || SECT_W >= ADDR_W ||
      PROG_CYC < 1 || ERASE_CYC < 1 || BULK_CYC < 1 || PD_CYC < 1 ||
      REL_CYC < 1) begin : g_bad
    $error("flash_seq: unsupported parameter values");
  end

  localparam int NSECT = 2 ** (ADDR_W - SECT_W);

  // ****************************************
  // Link side, clocked by the serial clock
  // ****************************************
  logic link_rst_n, first_ff, byte_done, buf_we, sig_on, so_ff;
  logic busy_meta_ff, busy_lnk_ff, in_prog_ff;
  logic [7:0] sh_ff, new_byte;
  frame_t frm_ff, nxt_frm;
  logic [7:0] page_buf [2**PAGE_W];

  // Select high holds the frame-start flag; no edge is needed at frame end.
  assign link_rst_n = rst_n_i & ~cs_n_i;
  assign new_byte = {sh_ff[6:0], si_i};
  assign byte_done = !first_ff && frm_ff.bitpos == 3'h7;
  assign buf_we = byte_done && frm_ff.cnt >= FIRST_DATA_END &&
                  frm_ff.opcode == OPC_PROG && !busy_lnk_ff;
  assign sig_on = frm_ff.opcode == OPC_REL && frm_ff.cnt >= CNT_HEADER &&
                  !busy_lnk_ff;

  // Frame start flag, set while deselected.
  always_ff @(posedge sck_i or negedge link_rst_n) begin
    if (!link_rst_n) first_ff <= 1'b1;
    else first_ff <= 1'b0;
  end

  // Busy level from the main clock, two flops before use.
  always_ff @(posedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_meta_ff <= 1'b0;
      busy_lnk_ff <= 1'b0;
    end else begin
      busy_meta_ff <= in_prog_ff;
      busy_lnk_ff <= busy_meta_ff;
    end
  end

  // Bits are gathered MSB first on rising edges.
  always_comb begin
    nxt_frm = frm_ff;
    if (first_ff) begin
      nxt_frm.cnt = 6'h01;
      nxt_frm.bitpos = 3'h1;
      nxt_frm.nbytes = 9'h000;
    end else begin
      nxt_frm.bitpos = frm_ff.bitpos + 3'h1;
      if (frm_ff.cnt < CNT_SAT) nxt_frm.cnt = frm_ff.cnt + 6'h01;
    end
    if (byte_done) begin
      if (frm_ff.cnt == LAST_OPC_BIT) nxt_frm.opcode = new_byte;
      else if (frm_ff.cnt == LAST_A2_BIT) nxt_frm.addr[23:16] = new_byte;
      else if (frm_ff.cnt == LAST_A1_BIT) nxt_frm.addr[15:8] = new_byte;
      else if (frm_ff.cnt == LAST_A0_BIT) begin
        nxt_frm.addr[7:0] = new_byte;
        nxt_frm.start = new_byte;
        nxt_frm.wptr = new_byte;
      end else if (buf_we) begin
        nxt_frm.wptr = frm_ff.wptr + 8'h01;
        if (frm_ff.nbytes != PAGE_BYTES)
          nxt_frm.nbytes = frm_ff.nbytes + 9'h001;
      end
    end
  end

  // Frame registers stay put after the frame for the main clock to read.
  always_ff @(posedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frm_ff <= '0;
      sh_ff <= 8'h00;
    end else begin
      frm_ff <= nxt_frm;
      sh_ff <= new_byte;
    end
  end

  // Page latch; later bytes overwrite earlier ones at the wrapped offset.
  always_ff @(posedge sck_i) begin
    if (buf_we) page_buf[frm_ff.wptr] <= new_byte;
  end

  // Signature shifted out on falling edges, repeating every eight bits.
  always_ff @(negedge sck_i or negedge link_rst_n) begin
    if (!link_rst_n) so_ff <= 1'b0;
    else so_ff <= sig_on & SIGNATURE[3'h7 - frm_ff.bitpos];
  end

  // ****************************************
  // Frame end detection in the main clock
  // ****************************************
  logic cs_meta_ff, cs_sync_ff, cs_prev_ff, cs_rise;
  logic [2:0] bp_meta_ff, bp_ff;

  // Select and protect bits each pass two flops.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
      bp_meta_ff <= 3'h0;
      bp_ff <= 3'h0;
    end else begin
      cs_meta_ff <= cs_n_i;
      cs_sync_ff <= cs_meta_ff;
      cs_prev_ff <= cs_sync_ff;
      bp_meta_ff <= bp_i;
      bp_ff <= bp_meta_ff;
    end
  end

  assign cs_rise = cs_sync_ff & ~cs_prev_ff;

  // ****************************************
  // Instruction decode at deselect
  // ****************************************
  op_state_t op_ff, nxt_op;
  pwr_state_t pwr_ff, nxt_pwr;
  logic [ADDR_W-1:0] eff_addr;
  logic [ADDR_W-SECT_W-1:0] sect;
  logic prot, idle, awake, prog_ok, sect_ok, bulk_ok, down_ok, wr_en_ok;
  logic rel_ok, start_prog, start_sect, start_bulk, start_op, set_latch;
  logic enter_down, rel_hit;

  assign eff_addr = frm_ff.addr[ADDR_W-1:0];
  assign sect = eff_addr[ADDR_W-1:SECT_W];
  // Nonzero protect bits guard the top 2**(bp-1) sectors.
  assign prot = bp_ff != 3'h0 &&
                int'(sect) >= NSECT - (1 << (int'(bp_ff) - 1));
  assign idle = op_ff == OP_IDLE;
  assign awake = pwr_ff == PWR_STANDBY;
  assign prog_ok = frm_ff.opcode == OPC_PROG && frm_ff.cnt == CNT_SAT &&
                   frm_ff.bitpos == 3'h0;
  assign sect_ok = frm_ff.opcode == OPC_SECT &&
                   frm_ff.cnt == CNT_HEADER;
  assign bulk_ok = frm_ff.opcode == OPC_BULK &&
                   frm_ff.cnt == CNT_OPCODE;
  assign down_ok = frm_ff.opcode == OPC_DOWN &&
                   frm_ff.cnt == CNT_OPCODE;
  assign wr_en_ok = frm_ff.opcode == OPC_WR_EN && frm_ff.cnt == CNT_OPCODE;
  assign rel_ok = frm_ff.opcode == OPC_REL && frm_ff.cnt >= CNT_OPCODE;
  assign start_prog = cs_rise && idle && awake && write_enable_latch_o &&
                      prog_ok && !prot;
  assign start_sect = cs_rise && idle && awake && write_enable_latch_o &&
                      sect_ok && !prot;
  assign start_bulk = cs_rise && idle && awake && write_enable_latch_o &&
                      bulk_ok && bp_ff == 3'h0;
  assign start_op = start_prog | start_sect | start_bulk;
  assign set_latch = cs_rise && idle && awake && wr_en_ok;
  assign enter_down = cs_rise && idle && awake && down_ok;
  assign rel_hit = cs_rise && idle && rel_ok;

  // ****************************************
  // Self-timed program and erase cycle
  // ****************************************
  logic [ADDR_W-1:0] op_addr_ff, walk_ff, mem_wa;
  logic [7:0] start_ff, rel, mem_wd;
  logic [8:0] nbytes_ff;
  logic [31:0] tmr_ff, tgt_ff;
  logic bulk_ff, touched, walk_end, mem_we;
  logic [7:0] mem [2**ADDR_W];

  assign rel = walk_ff[7:0] - start_ff;
  assign touched = nbytes_ff == PAGE_BYTES ||
                   {1'b0, rel} < nbytes_ff;
  assign walk_end = op_ff == OP_PROG ? &walk_ff[PAGE_W-1:0] :
                    bulk_ff ? &walk_ff : &walk_ff[SECT_W-1:0];
  assign mem_wa = op_ff == OP_PROG ?
                  {op_addr_ff[ADDR_W-1:PAGE_W], walk_ff[PAGE_W-1:0]} :
                  bulk_ff ? walk_ff :
                  {op_addr_ff[ADDR_W-1:SECT_W], walk_ff[SECT_W-1:0]};
  assign mem_wd = op_ff == OP_PROG ?
                  mem[mem_wa] & page_buf[walk_ff[PAGE_W-1:0]] :
                  ERASED_BYTE;
  assign mem_we = (op_ff == OP_PROG && touched) || op_ff == OP_ERASE;

  // Walk the target bytes, then wait out the remaining cycle time.
  always_comb begin
    nxt_op = op_ff;
    case (op_ff)
      OP_IDLE: begin
        if (start_prog) nxt_op = OP_PROG;
        else if (start_sect || start_bulk) nxt_op = OP_ERASE;
      end
      OP_PROG, OP_ERASE: begin
        if (walk_end) nxt_op = OP_WAIT;
      end
      OP_WAIT: begin
        if (tmr_ff >= tgt_ff) nxt_op = OP_IDLE;
      end
      default: nxt_op = OP_IDLE;
    endcase
  end

  // Cycle state, target and progress flag.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_ff <= OP_IDLE;
      op_addr_ff <= '0;
      walk_ff <= '0;
      start_ff <= 8'h00;
      nbytes_ff <= 9'h000;
      bulk_ff <= 1'b0;
      tmr_ff <= 32'h0000_0000;
      tgt_ff <= 32'h0000_0000;
      in_prog_ff <= 1'b0;
    end else begin
      op_ff <= nxt_op;
      in_prog_ff <= nxt_op != OP_IDLE;
      tmr_ff <= idle ? 32'h0000_0001 : tmr_ff + 32'h0000_0001;
      walk_ff <= idle ? '0 : walk_ff + 1'b1;
      if (start_op) begin
        op_addr_ff <= eff_addr;
        start_ff <= frm_ff.start;
        nbytes_ff <= frm_ff.nbytes;
        bulk_ff <= start_bulk;
        tgt_ff <= start_prog ? 32'(PROG_CYC) :
                  start_sect ? 32'(ERASE_CYC) : 32'(BULK_CYC);
      end
    end
  end

  // Write enable latch: set by its instruction, cleared when a cycle starts.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) write_enable_latch_o <= 1'b0;
    else if (start_op) write_enable_latch_o <= 1'b0;
    else if (set_latch) write_enable_latch_o <= 1'b1;
  end

  // Array write and the registered inspection read port.
  always_ff @(posedge clock_i) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) rd_data_o <= 8'h00;
    else rd_data_o <= mem[rd_addr_i];
  end

  // ****************************************
  // Power modes
  // ****************************************
  logic [31:0] ptmr_ff;

  // Only the power-down instruction leads to the deep state.
  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      PWR_STANDBY: begin
        if (enter_down) nxt_pwr = PWR_ENTER;
      end
      PWR_ENTER: begin
        if (ptmr_ff >= 32'(PD_CYC)) nxt_pwr = PWR_DEEP;
      end
      PWR_DEEP: begin
        if (rel_hit) nxt_pwr = PWR_RELEASE;
      end
      PWR_RELEASE: begin
        if (ptmr_ff >= 32'(REL_CYC)) nxt_pwr = PWR_STANDBY;
      end
      default: nxt_pwr = PWR_STANDBY;
    endcase
  end

  // Power state, delay counter and the deep power-down flag.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_ff <= PWR_STANDBY;
      ptmr_ff <= 32'h0000_0000;
      deep_pd_o <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
      ptmr_ff <= nxt_pwr != pwr_ff ? 32'h0000_0001 :
                 ptmr_ff + 32'h0000_0001;
      deep_pd_o <= nxt_pwr == PWR_DEEP;
    end
  end

  assign so_o = so_ff;
  assign write_in_progress_o = in_prog_ff;

  // ****************************************
  // Assertions
  // ****************************************
  latch_gate_a: assert property ($rose(in_prog_ff) |->
    $past(write_enable_latch_o))
    else $error("cycle started without write enable");
  prog_clear_a: assert property (mem_we && op_ff == OP_PROG |->
    (mem_wd & ~mem[mem_wa]) == 8'h00)
    else $error("program tried to set a bit");
  busy_latch_a: assert property (in_prog_ff |->
    !write_enable_latch_o)
    else $error("latch set during cycle");
  prot_skip_a: assert property (cs_rise && idle && prot &&
    awake && (prog_ok || sect_ok) |=> !in_prog_ff)
    else $error("protected target was started");
  bulk_prot_a: assert property (cs_rise && bulk_ok &&
    bp_ff != 3'h0 |=> !$rose(in_prog_ff))
    else $error("bulk erase ran with protection");
  down_delay_a: assert property ($rose(pwr_ff == PWR_ENTER) |->
    !deep_pd_o [*2])
    else $error("deep state entered early");
  down_ignore_a: assert property (cs_rise && pwr_ff == PWR_DEEP |=>
    !$rose(in_prog_ff) && !$rose(write_enable_latch_o))
    else $error("write accepted while powered down");
  down_busy_a: assert property (cs_rise && !idle |=>
    pwr_ff == $past(pwr_ff) && in_prog_ff == ($past(nxt_op) != OP_IDLE))
    else $error("instruction disturbed busy cycle");
  rel_fast_a: assert property (rel_hit && pwr_ff == PWR_STANDBY |=>
    pwr_ff == PWR_STANDBY)
    else $error("release from standby not immediate");
  wait_end_a: assert property ($fell(in_prog_ff) |->
    $past(tmr_ff) >= $past(tgt_ff))
    else $error("cycle ended before its time");

  prog_cov_c: cover property (start_prog ##1 in_prog_ff);
  sect_cov_c: cover property (start_sect ##1 in_prog_ff);
  bulk_cov_c: cover property (start_bulk ##1 in_prog_ff);
  down_cov_c: cover property ($rose(deep_pd_o) ##[1:1000] $fell(deep_pd_o));

endmodule : flash_seq

`default_nettype wire

/* File: core/flash_seq_pkg.sv */
// Shared constants, state encodings and the frame carrier for the sequencer.
package flash_seq_pkg;

  // ****************************************
  // Clock and self-timed durations
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROGRAM_CYCLE_TIME_NS = 5000;
  localparam int SECTOR_ERASE_TIME_NS = 20000;
  localparam int BULK_ERASE_TIME_NS = 60000;
  localparam int POWER_DOWN_ENTRY_DELAY_NS = 3000;
  localparam int RELEASE_DELAY_NS = 3000;

  // ****************************************
  // Frame layout, counted in received bits
  // ****************************************
  localparam int BYTE_W = 8;
  localparam int PAGE_W = 8;
  localparam int ADDR_FULL_W = 24;
  localparam logic [5:0] LAST_OPC_BIT = 6'h07;
  localparam logic [5:0] LAST_A2_BIT = 6'h0F;
  localparam logic [5:0] LAST_A1_BIT = 6'h17;
  localparam logic [5:0] LAST_A0_BIT = 6'h1F;
  localparam logic [5:0] FIRST_DATA_END = 6'h27;
  localparam logic [5:0] CNT_OPCODE = 6'h08;
  localparam logic [5:0] CNT_HEADER = 6'h20;
  localparam logic [5:0] CNT_SAT = 6'h28;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ****************************************
  // State encodings
  // ****************************************
  typedef enum logic [3:0] {
    OP_IDLE  = 4'h1,
    OP_PROG  = 4'h2,
    OP_ERASE = 4'h4,
    OP_WAIT  = 4'h8
  } op_state_t;

  typedef enum logic [3:0] {
    PWR_STANDBY = 4'h1,
    PWR_ENTER   = 4'h2,
    PWR_DEEP    = 4'h4,
    PWR_RELEASE = 4'h8
  } pwr_state_t;

  // Everything the serial side has gathered about the current frame.
  typedef struct packed {
    logic [7:0] opcode;
    logic [ADDR_FULL_W-1:0] addr;
    logic [7:0] start;
    logic [7:0] wptr;
    logic [8:0] nbytes;
    logic [5:0] cnt;
    logic [2:0] bitpos;
  } frame_t;

endpackage : flash_seq_pkg

/* File: verif/flash_host_model.sv */
// Serial host model that frames instructions on the link clock.
`timescale 1ns/1ps
`default_nettype none

module flash_host_model (
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i
);
  // ****************************************
  // Frame engine
  // ****************************************
  logic [7:0] txq[$];
  logic [7:0] rxq[$];

  // The link clock stands low and select high between frames.
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // Sends the queued bytes MSB first plus stray bits, then deselects.
  task automatic xfer(input int extra);
    logic [7:0] r;
    r = 8'h00;
    rxq.delete();
    #1.7 cs_n_o = 1'b0;
    for (int k = 0; k < txq.size() * 8 + extra; k++) begin
      si_o = (k < txq.size() * 8) ? txq[k / 8][7 - k % 8] : ~si_o;
      #3 sck_o = 1'b1;
      r = {r[6:0], so_i};
      if (k % 8 == 7) rxq.push_back(r);
      #3 sck_o = 1'b0;
    end
    #3 cs_n_o = 1'b1;
    si_o = ~si_o;
    txq.delete();
  endtask : xfer
endmodule : flash_host_model
`default_nettype wire

/* File: verif/serial_flash_program_erase_power_tb_top.sv */
// Self-checking bench for the serial flash sequencer.
`timescale 1ns/1ps
`default_nettype none

module serial_flash_program_erase_power_tb_top;
  import flash_seq_pkg::*;
  // ****************************************
  // Bench setup
  // ****************************************
  localparam int AW = 12;
  localparam int SW = 10;
  localparam int CYC = 4;
  localparam logic [7:0] SIG = 8'h3C; // Arbitrary value.
  logic clk;
  logic rst_n;
  logic [2:0] bp;
  logic [AW-1:0] rd_addr;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic prog_busy;
  logic wr_latch;
  logic deep_pd;
  logic [7:0] rd_data;
  logic [7:0] mem [0:(1<<AW)-1];
  logic [31:0] a;
  integer seed;
  int n_fail;
  int cmp_count;

  flash_seq #(.ADDR_W(AW), .SECT_W(SW), .SIGNATURE(SIG), .PROG_CYC(CYC),
    .ERASE_CYC(CYC), .BULK_CYC(CYC), .PD_CYC(CYC), .REL_CYC(CYC))
  flash_seq_i (.clock_i(clk), .rst_n_i(rst_n), .sck_i(sck), .cs_n_i(cs_n),
    .si_i(si), .bp_i(bp), .rd_addr_i(rd_addr), .so_o(so),
    .write_in_progress_o(prog_busy), .write_enable_latch_o(wr_latch),
    .deep_pd_o(deep_pd), .rd_data_o(rd_data));
  flash_host_model flash_host_model_i (.sck_o(sck), .cs_n_o(cs_n),
    .si_o(si), .so_i(so));

  // Main clock, free running.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // Queues one byte, or an opcode with its address, for the host.
  task automatic q(input logic [7:0] b);
    flash_host_model_i.txq.push_back(b);
  endtask : q

  task automatic hdr(input logic [7:0] opc, input logic [23:0] ad);
    q(opc);
    q(ad[23:16]);
    q(ad[15:8]);
    q(ad[7:0]);
  endtask : hdr

  // Sends a frame, checks whether a cycle began, waits until it ends.
  task automatic run(input int extra, input logic busy);
    int k;
    flash_host_model_i.xfer(extra);
    repeat (6) @(posedge clk);
    #1 check("progress", 8'(prog_busy), 8'(busy));
    k = 0;
    while (prog_busy !== 1'b0 && k < 12000) begin
      @(posedge clk);
      k++;
    end
    if (k == 12000) check("progress end", 8'h01, 8'h00);
    repeat (2) @(posedge clk);
    #1;
  endtask : run

  task automatic wr_en();
    q(8'h06);
    run(0, 1'b0);
    check("latch", 8'(wr_latch), 8'h01);
  endtask : wr_en

  // Programs n random bytes from ad; the model keeps only the last 256.
  task automatic prog(input logic [23:0] ad, input int n, input int extra,
                      input logic go);
    logic [7:0] pg [256];
    bit hit [256];
    logic [7:0] d;
    logic [7:0] off;
    hdr(8'h02, ad);
    foreach (hit[i]) hit[i] = 1'b0;
    for (int i = 0; i < n; i++) begin
      d = $random(seed);
      off = ad[7:0] + 8'(i);
      pg[off] = d;
      hit[off] = 1'b1;
      q(d);
    end
    run(extra, go);
    for (int i = 0; i < 256; i++) begin
      if (go && hit[i]) mem[{ad[AW-1:8], 8'(i)}] &= pg[i];
    end
  endtask : prog

  // Erases the sector holding ad when go is set.
  task automatic sect_erase(input logic [23:0] ad, input int extra,
                            input logic go);
    hdr(8'hD8, ad);
    run(extra, go);
    for (int j = 0; j < (1 << SW); j++) begin
      if (go) mem[{ad[AW-1:SW], SW'(j)}] = ERASED_BYTE;
    end
  endtask : sect_erase

  // Reads back one whole page through the inspection port.
  task automatic chk_page(input logic [AW-1:0] pa);
    for (int i = 0; i < 256; i++) begin
      @(posedge clk) rd_addr <= {pa[AW-1:8], 8'(i)};
      repeat (2) @(posedge clk);
      #1 check("array", rd_data, mem[{pa[AW-1:8], 8'(i)}]);
    end
  endtask : chk_page

  // Release with dummy bytes; the signature must come out twice.
  task automatic rel_sig(input int extra);
    q(8'hAB);
    repeat (5) q(8'h00);
    flash_host_model_i.xfer(extra);
    check("sig", flash_host_model_i.rxq[4], SIG);
    check("sig rep", flash_host_model_i.rxq[5], SIG);
    repeat (CYC + 8) @(posedge clk);
    #1 check("pd off", 8'(deep_pd), 8'h00);
  endtask : rel_sig

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed = 88;
    n_fail = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    bp = 3'h0;
    rd_addr = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check("idle", {5'h00, prog_busy, wr_latch, deep_pd}, 8'h00);
    q(8'hC7);
    run(0, 1'b0);
    wr_en();
    q(8'hC7);
    run(0, 1'b1);
    check("latch clr", 8'(wr_latch), 8'h00);
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    wr_en();
    prog(24'hE003F0, 40, 0, 1'b1);
    wr_en();
    prog(24'h000310, 20, 0, 1'b1);
    chk_page(12'h300);
    wr_en();
    prog(24'h000500, 260, 0, 1'b1);
    for (int r = 0; r < 3; r++) begin
      wr_en();
      a = $random(seed);
      prog(a[23:0], 1 + a[30:24], 0, 1'b1);
      chk_page(a[AW-1:0]);
    end
    wr_en();
    prog(24'h000700, 5, 3, 1'b0);
    check("latch kept", 8'(wr_latch), 8'h01);
    chk_page(12'h700);
    sect_erase(24'h000700, 5, 1'b0);
    sect_erase(24'hA00600, 0, 1'b1);
    chk_page(12'h500);
    @(posedge clk) bp <= 3'h1;
    wr_en();
    prog(24'h000C40, 8, 0, 1'b0);
    sect_erase(24'h000F00, 0, 1'b0);
    q(8'hC7);
    run(0, 1'b0);
    prog(24'h000040, 8, 0, 1'b1);
    chk_page(12'h000);
    @(posedge clk) bp <= 3'h0;
    wr_en();
    q(8'hC7);
    run(2, 1'b0);
    q(8'hB9);
    run(1, 1'b0);
    check("pd stray", 8'(deep_pd), 8'h00);
    q(8'hB9);
    flash_host_model_i.xfer(0);
    repeat (2) @(posedge clk);
    #1 check("pd early", 8'(deep_pd), 8'h00);
    repeat (CYC + 8) @(posedge clk);
    #1 check("pd", 8'(deep_pd), 8'h01);
    prog(24'h000080, 4, 0, 1'b0);
    rel_sig(0);
    rel_sig(3);
    wr_en();
    q(8'hC7);
    flash_host_model_i.xfer(0);
    repeat (6) @(posedge clk);
    q(8'hB9);
    run(0, 1'b1);
    check("pd busy", 8'(deep_pd), 8'h00);
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    wr_en();
    hdr(8'hD8, 24'h000000);
    flash_host_model_i.xfer(0);
    repeat (6) @(posedge clk);
    q(8'hAB);
    repeat (4) q(8'h00);
    run(0, 1'b1);
    chk_page(12'h000);
    tally_and_finish();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #900000;
    n_fail++;
    tally_and_finish();
  end
endmodule : serial_flash_program_erase_power_tb_top
`default_nettype wire
